/* File: seew_defs.vh */
`ifndef SEEW_DEFS_VH
`define SEEW_DEFS_VH

// ********************************************
// control byte layout
// ********************************************
`define SEEW_TYPE_CODE 4'hA
`define SEEW_TYPE_HI 7
`define SEEW_TYPE_LO 4
`define SEEW_CS_HI 3
`define SEEW_CS_LO 1
`define SEEW_RW_BIT 0

// ********************************************
// array geometry and timing defaults
// ********************************************
`define SEEW_ADDR_W 16
`define SEEW_PAGE_SIZE 64
`define SEEW_ADDR_BYTES 2
`define SEEW_WRITE_CYCLES 125000
`define SEEW_ADDR_RESET 1'h0

`endif

/* File: seew_mst.sv */
`timescale 1ns/1ps
// ****************************
// two-wire bus master model
// ****************************
module seew_mst (
    // system clock paces the bus
    input wire clk,
    // bus lines, released means high
    output reg scl,
    output reg sda_rel,
    input wire sda_line
);
    // idle high; clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // step n clocks, then change off the edge
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one bit clock; sample late in high so the ack has settled
    task bitc(input logic v, output logic s);
        wt(2);
        sda_rel = v;
        wt(2);
        scl = 1'b1;
        wt(3);
        s = sda_line;
        wt(1);
        scl = 1'b0;
    endtask
    task start;
        wt(2);
        sda_rel = 1'b1;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_rel = 1'b0;
        wt(4);
        scl = 1'b0;
    endtask
    task stop;
        wt(2);
        sda_rel = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_rel = 1'b1;
        wt(4);
    endtask
    // msb first, ack read in ninth clock
    task wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitc(b[i], s);
        end
        bitc(1'b1, s);
        ack = (s === 1'b0);
    endtask
endmodule // seew_mst

/* File: seew_slave.v */
// Notes on behaviour
// - control byte accepted only with type code 1010 in top nibble
// - chip-select bits must equal the three chip-select pin levels
// - last control bit: one selects read, zero selects write
// - two address bytes arrive high byte first, assembled in order
// - address bits above array size are ignored
// - matching control byte is acknowledged, address bytes follow
// - up to eight devices share a bus; reads never cross devices
// - write control byte acknowledged in ninth clock
// - every address byte acknowledged and loaded into address counter
// - smallest configuration uses only low four bits of address byte
// - data byte acknowledged; Stop starts the self-timed write cycle
// - write protect: still acknowledge, no write, ready at once
// - after byte write the address counter moves to next location
// - no acknowledge of any command while write cycle runs
// - page bytes buffered, committed after Stop, counter steps per byte
// - over one page of data wraps buffer, later bytes replace earlier
// - any start, any count up to page; only addressed bytes change
// - page write wraps at page end to same page start
// - write-protect sampled before Stop; later changes ignored
// - acknowledge holds data line low through the ninth clock high
// - data falling while clock high is Start
// - data rising while clock high is Stop
`timescale 1ns/1ps
`include "seew_defs.vh"

module seew_slave #(
    parameter ADDR_W = `SEEW_ADDR_W,
    parameter PAGE_SIZE = `SEEW_PAGE_SIZE,
    parameter ADDR_BYTES = `SEEW_ADDR_BYTES,
    parameter WRITE_CYCLES = `SEEW_WRITE_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // two-wire bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out_ff,
    output reg sda_oe_n_ff,
    // strap pins
    input wire chip_select_bit_zero,
    input wire chip_select_bit_one,
    input wire chip_select_bit_two,
    input wire wp_in,
    // status towards read logic
    output reg busy_ff,
    output reg [ADDR_W-1:0] addr_ctr_ff,
    output reg rd_sel_ff,
    // array write port, one byte per cycle during commit
    output reg mem_we_ff,
    output reg [ADDR_W-1:0] mem_addr_ff,
    output reg [7:0] mem_data_ff
);

// a page of one byte still needs one index bit
localparam PAGE_W = (PAGE_SIZE <= 1) ? 1 : $clog2(PAGE_SIZE);

// ********************************************
// states, one-hot
// ********************************************
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_CTRL = 6'h02;
localparam [5:0] ST_ADDR = 6'h04;
localparam [5:0] ST_DATA = 6'h08;
// ST_IGN swallows bits until the next start or stop
localparam [5:0] ST_IGN = 6'h10;
localparam [5:0] ST_COMMIT = 6'h20;

// ********************************************
// pin synchronisers
// ********************************************
// straps are treated as asynchronous pins as well
wire scl_s;
wire sda_s;
wire cs0_s;
wire cs1_s;
wire cs2_s;
wire wp_s;

seew_sync u_scl (.clk(clk), .rst(rst), .pin_in(scl_in), .pin_sync_ff(scl_s));
seew_sync u_sda (.clk(clk), .rst(rst), .pin_in(sda_in), .pin_sync_ff(sda_s));
seew_sync u_cs0 (.clk(clk), .rst(rst), .pin_in(chip_select_bit_zero),
    .pin_sync_ff(cs0_s));
seew_sync u_cs1 (.clk(clk), .rst(rst), .pin_in(chip_select_bit_one),
    .pin_sync_ff(cs1_s));
seew_sync u_cs2 (.clk(clk), .rst(rst), .pin_in(chip_select_bit_two),
    .pin_sync_ff(cs2_s));
seew_sync u_wp (.clk(clk), .rst(rst), .pin_in(wp_in), .pin_sync_ff(wp_s));

// ********************************************
// edge and condition detection
// ********************************************
reg scl_d_ff;
reg sda_d_ff;

// delay flops reset to the idle level, so no false edge follows reset
always @(posedge clk or posedge rst) begin
    if (rst) begin
        scl_d_ff <= 1'b1;
        sda_d_ff <= 1'b1;
    end else begin
        scl_d_ff <= scl_s;
        sda_d_ff <= sda_s;
    end
end

wire scl_rise = scl_s & ~scl_d_ff;
wire scl_fall = ~scl_s & scl_d_ff;
wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

// ********************************************
// write cycle timer
// ********************************************
reg tmr_start;
wire tmr_busy;

seew_timer #(.CYCLES(WRITE_CYCLES)) u_tmr (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .busy_ff(tmr_busy)
);

// ********************************************
// busy view
// ********************************************
// the start pulse covers the one cycle before the timer reports busy,
// so neither the busy output nor a poll sees a gap after the commit
wire cycle_busy = tmr_busy | tmr_start;

// ********************************************
// page buffer
// ********************************************
// page geometry from parameters
reg [7:0] page_mem [0:PAGE_SIZE-1];
reg [PAGE_SIZE-1:0] page_vld_ff;

// ********************************************
// protocol state
// ********************************************
reg [5:0] state_ff;
reg [3:0] bit_cnt_ff;
reg [7:0] shift_ff;
reg ack_phase_ff;
reg ack_go_ff;
reg [1:0] addr_idx_ff;
reg [ADDR_W-1:0] page_base_ff;
reg got_data_ff;
reg wp_lat_ff;
reg [PAGE_W:0] commit_idx_ff;
reg [7:0] rx_byte;
reg [2:0] cs_pins;
reg [ADDR_W+7:0] addr_shift;

// rx_byte is the byte as it stands once the current bit is in;
// address bytes shift in from the low end, and whatever is pushed
// past ADDR_W falls off, which drops the unused upper address bits
always @* begin
    rx_byte = {shift_ff[6:0], sda_s};
    cs_pins = {cs2_s, cs1_s, cs0_s};
    addr_shift = {addr_ctr_ff, rx_byte};
end

// page-local increment keeps the page bits fixed
// so a long page write wraps onto the start of the same page
function [ADDR_W-1:0] page_inc;
    input [ADDR_W-1:0] a;
    reg [ADDR_W-1:0] nxt;
    begin
        nxt = a + {{(ADDR_W-1){1'b0}}, 1'b1};
        page_inc = (a & ~(PAGE_SIZE[ADDR_W-1:0] - 1'b1)) |
            (nxt & (PAGE_SIZE[ADDR_W-1:0] - 1'b1));
    end
endfunction

// ********************************************
// main bus engine
// ********************************************
// sample on scl rise, drive ack after scl fall
always @(posedge clk or posedge rst) begin
    if (rst) begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        shift_ff <= 8'h00;
        ack_phase_ff <= 1'b0;
        ack_go_ff <= 1'b0;
        addr_idx_ff <= 2'h0;
        addr_ctr_ff <= {ADDR_W{`SEEW_ADDR_RESET}};
        page_base_ff <= {ADDR_W{1'b0}};
        got_data_ff <= 1'b0;
        wp_lat_ff <= 1'b0;
        commit_idx_ff <= {(PAGE_W+1){1'b0}};
        page_vld_ff <= {PAGE_SIZE{1'b0}};
        sda_out_ff <= 1'b1;
        sda_oe_n_ff <= 1'b1;
        rd_sel_ff <= 1'b0;
        busy_ff <= 1'b0;
        mem_we_ff <= 1'b0;
        mem_addr_ff <= {ADDR_W{1'b0}};
        mem_data_ff <= 8'h00;
        tmr_start <= 1'b0;
    end else begin
        tmr_start <= 1'b0;
        mem_we_ff <= 1'b0;
        // busy spans the commit walk and the timed cycle without a break
        busy_ff <= cycle_busy | (state_ff == ST_COMMIT);
        // the ack bit is never shifted: ack_phase masks its scl rise
        // release the line only after the ack clock falls
        if (scl_fall) begin
            if (ack_go_ff) begin
                sda_out_ff <= 1'b0;
                sda_oe_n_ff <= 1'b0;
                ack_go_ff <= 1'b0;
                ack_phase_ff <= 1'b1;
            end else if (ack_phase_ff) begin
                sda_out_ff <= 1'b1;
                sda_oe_n_ff <= 1'b1;
                ack_phase_ff <= 1'b0;
            end
        end
        case (state_ff)
            ST_COMMIT: begin
                // the walk covers the whole page: fixed length, any count;
                // starts are not looked at here, a poll just gets no ack
                // only marked bytes reach the array
                if (commit_idx_ff == PAGE_SIZE[PAGE_W:0]) begin
                    state_ff <= ST_IDLE;
                    tmr_start <= 1'b1;
                    page_vld_ff <= {PAGE_SIZE{1'b0}};
                end else begin
                    if (page_vld_ff[commit_idx_ff[PAGE_W-1:0]]) begin
                        mem_we_ff <= 1'b1;
                        mem_addr_ff <= page_base_ff |
                            {{(ADDR_W-PAGE_W){1'b0}},
                            commit_idx_ff[PAGE_W-1:0]};
                        mem_data_ff <= page_mem[commit_idx_ff[PAGE_W-1:0]];
                    end
                    commit_idx_ff <= commit_idx_ff + 1'b1;
                end
            end
            default: begin
                if (start_det) begin
                    // busy device ignores the control byte
                    state_ff <= cycle_busy ? ST_IGN : ST_CTRL;
                    bit_cnt_ff <= 4'h0;
                    rd_sel_ff <= 1'b0;
                    got_data_ff <= 1'b0;
                    ack_go_ff <= 1'b0;
                    page_vld_ff <= {PAGE_SIZE{1'b0}};
                end else if (stop_det) begin
                    // the stop's own scl rise may shift a stray bit; harmless
                    sda_out_ff <= 1'b1;
                    sda_oe_n_ff <= 1'b1;
                    ack_phase_ff <= 1'b0;
                    if (state_ff == ST_DATA && got_data_ff && !wp_lat_ff) begin
                        state_ff <= ST_COMMIT;
                        commit_idx_ff <= {(PAGE_W+1){1'b0}};
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end else if (scl_rise && !ack_phase_ff &&
                        state_ff != ST_IDLE && state_ff != ST_IGN) begin
                    shift_ff <= rx_byte;
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    // a protect change after the stop never reaches the latch
                    // protect level tracked until stop
                    wp_lat_ff <= wp_s;
                    if (bit_cnt_ff == 4'h7) begin
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == ST_CTRL) begin
                            if (rx_byte[`SEEW_TYPE_HI:`SEEW_TYPE_LO] ==
                                    `SEEW_TYPE_CODE &&
                                    rx_byte[`SEEW_CS_HI:`SEEW_CS_LO] ==
                                    cs_pins) begin
                                ack_go_ff <= 1'b1;
                                rd_sel_ff <= rx_byte[`SEEW_RW_BIT];
                                state_ff <= rx_byte[`SEEW_RW_BIT] ?
                                    ST_IGN : ST_ADDR;
                                addr_idx_ff <= 2'h0;
                            end else begin
                                state_ff <= ST_IGN;
                            end
                        end else if (state_ff == ST_ADDR) begin
                            ack_go_ff <= 1'b1;
                            addr_idx_ff <= addr_idx_ff + 2'h1;
                            // narrow array keeps low bits only
                            addr_ctr_ff <= addr_shift[ADDR_W-1:0];
                            if (addr_idx_ff + 2'h1 ==
                                    ADDR_BYTES[1:0]) begin
                                state_ff <= ST_DATA;
                            end
                        end else begin
                            ack_go_ff <= 1'b1;
                            got_data_ff <= 1'b1;
                            page_base_ff <= addr_ctr_ff &
                                ~(PAGE_SIZE[ADDR_W-1:0] - 1'b1);
                            page_vld_ff[addr_ctr_ff[PAGE_W-1:0]] <= 1'b1;
                            addr_ctr_ff <= page_inc(addr_ctr_ff);
                        end
                    end
                end
            end
        endcase
    end
end

// ********************************************
// page buffer storage
// ********************************************
// written without reset: the valid marks decide what is committed,
// so stale bytes from an earlier frame never reach the array
always @(posedge clk) begin
    if (state_ff == ST_DATA && scl_rise && !ack_phase_ff &&
            !start_det && !stop_det && bit_cnt_ff == 4'h7) begin
        page_mem[addr_ctr_ff[PAGE_W-1:0]] <= rx_byte;
    end
end

endmodule // seew_slave

/* File: seew_slave_asserts.sv */
`timescale 1ns/1ps
// ****************************
// write path checker
// ****************************
module seew_slave_asserts #(
    parameter ADDR_W = 16,
    parameter PAGE_SIZE = 64,
    parameter ADDR_BYTES = 2,
    parameter WRITE_CYCLES = 125000
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // bus pins
    input wire scl_in,
    input wire sda_in,
    input wire sda_out_ff,
    input wire sda_oe_n_ff,
    // straps
    input wire chip_select_bit_zero,
    input wire chip_select_bit_one,
    input wire chip_select_bit_two,
    input wire wp_in,
    // status and array port
    input wire busy_ff,
    input wire [ADDR_W-1:0] addr_ctr_ff,
    input wire rd_sel_ff,
    input wire mem_we_ff,
    input wire [ADDR_W-1:0] mem_addr_ff,
    input wire [7:0] mem_data_ff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // busy length in a counter, too long for a repetition
    reg [31:0] busy_len_ff;
    wire [31:0] nxt_busy_len = busy_ff ? busy_len_ff + 32'h1 : 32'h0;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_len_ff <= 32'h0;
        end else begin
            busy_len_ff <= nxt_busy_len;
        end
    end
    // ack low phase and back-to-back commit pulses
    sequence s_ack_hold;
        (!sda_oe_n_ff) [*6];
    endsequence
    sequence s_two_we;
        mem_we_ff ##1 mem_we_ff;
    endsequence
    a_ack_hold: assert property ($fell(sda_oe_n_ff) |->
        s_ack_hold ##[1:8] sda_oe_n_ff) else $error("ack hold wrong");
    a_drive_low_only: assert property (!sda_oe_n_ff |->
        !sda_out_ff) else $error("drives line high");
    a_busy_no_ack: assert property (busy_ff |->
        sda_oe_n_ff) else $error("ack while busy");
    a_we_in_busy: assert property (mem_we_ff |->
        busy_ff) else $error("write outside cycle");
    a_wp_no_cycle: assert property ($rose(busy_ff) |->
        !$past(wp_in, 8)) else $error("cycle under protect");
    a_busy_length: assert property ($fell(busy_ff) |->
        busy_len_ff >= WRITE_CYCLES + PAGE_SIZE &&
        busy_len_ff <= WRITE_CYCLES + PAGE_SIZE + 4)
        else $error("busy length wrong");
    a_we_same_page: assert property (s_two_we |->
        mem_addr_ff / PAGE_SIZE == $past(mem_addr_ff) / PAGE_SIZE &&
        mem_addr_ff > $past(mem_addr_ff)) else $error("page order");
    a_ctr_hold_busy: assert property (busy_ff && $past(busy_ff) |->
        $stable(addr_ctr_ff)) else $error("counter moved");
    // ack edges fall in clock low
    a_ack_edge_low: assert property ($changed(sda_oe_n_ff) |->
        !scl_in) else $error("ack moved in clock high");
    // read select starts no array write
    a_rd_no_write: assert property (rd_sel_ff |->
        !mem_we_ff) else $error("write after read select");
endmodule // seew_slave_asserts

bind seew_slave seew_slave_asserts #(
    .ADDR_W(ADDR_W), .PAGE_SIZE(PAGE_SIZE),
    .ADDR_BYTES(ADDR_BYTES), .WRITE_CYCLES(WRITE_CYCLES)
) u_seew_chk (
    .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_ff(sda_out_ff), .sda_oe_n_ff(sda_oe_n_ff),
    .chip_select_bit_zero(chip_select_bit_zero),
    .chip_select_bit_one(chip_select_bit_one),
    .chip_select_bit_two(chip_select_bit_two), .wp_in(wp_in),
    .busy_ff(busy_ff), .addr_ctr_ff(addr_ctr_ff), .rd_sel_ff(rd_sel_ff),
    .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
    .mem_data_ff(mem_data_ff)
);

/* File: seew_slave_tb.sv */
`timescale 1ns/1ps
// ****************************
// write path testbench
// ****************************
module seew_slave_tb;
    localparam int PS = 8;
    localparam int AW = 12;
    localparam int WC = 50;
    // straps, model state and scores
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic [2:0] cs = 3'h0;
    logic a;
    int err_total = 0;
    int compares = 0;
    int expq[$];
    wire scl, m_rel, sda_o, sda_oe_n, busy, rd_sel, we;
    wire [AW-1:0] ctr, maddr;
    wire [7:0] mdata;
    // pulled-up line: low when either side pulls
    wire sda = m_rel & (sda_oe_n | sda_o);
    seew_mst m (.clk(clk), .scl(scl), .sda_rel(m_rel), .sda_line(sda));
    seew_slave #(.ADDR_W(AW), .PAGE_SIZE(PS), .ADDR_BYTES(2),
        .WRITE_CYCLES(WC)) DUT (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out_ff(sda_o), .sda_oe_n_ff(sda_oe_n),
        .chip_select_bit_zero(cs[0]), .chip_select_bit_one(cs[1]),
        .chip_select_bit_two(cs[2]), .wp_in(wp), .busy_ff(busy),
        .addr_ctr_ff(ctr), .rd_sel_ff(rd_sel), .mem_we_ff(we),
        .mem_addr_ff(maddr), .mem_data_ff(mdata));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task chk_bit(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %b got %b", n, e, g);
        end
    endtask
    task chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task stop_test;
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task ctl(input logic [7:0] b, input logic e);
        m.start;
        m.wbyte(b, a);
        chk_bit("ack", e, a);
    endtask
    // array port: each pulse must be the next model entry
    always @(posedge clk) begin
        #2;
        if (we === 1'b1) begin
            chk_word("mem", expq.size() > 0 ? expq.pop_front() : -1,
                {4'h0, maddr, mdata});
        end
    end
    // one write frame; wp flips right after stop to show it is ignored
    task automatic wr(input int n, input logic prot);
        int ad;
        int p;
        int pg[int];
        logic [7:0] d;
        ad = $urandom;
        p = ad & ((1 << AW) - 1);
        wp = prot;
        ctl({4'hA, cs, 1'b0}, 1'b1);
        m.wbyte(ad[15:8], a);
        chk_bit("ahi", 1'b1, a);
        m.wbyte(ad[7:0], a);
        chk_bit("alo", 1'b1, a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            m.wbyte(d, a);
            chk_bit("dat", 1'b1, a);
            pg[p % PS] = d;
            p = p - p % PS + (p + 1) % PS;
        end
        // model entries go in before the stop that launches the commit
        foreach (pg[k]) begin
            if (!prot) begin
                expq.push_back((p - p % PS + k) * 256 + pg[k]);
            end
        end
        m.stop;
        wp = !prot;
        if (prot) begin
            m.wt(4);
            chk_bit("busy", 1'b0, busy);
            ctl({4'hA, cs, 1'b0}, 1'b1);
        end else begin
            m.start;
            m.wbyte({4'hA, cs, 1'b0}, a);
            chk_bit("poll", 1'b0, a);
            for (int k = 0; k < 20 && !a; k++) begin
                m.start;
                m.wbyte({4'hA, cs, 1'b0}, a);
            end
            chk_bit("done", 1'b1, a);
        end
        m.stop;
        chk_word("ctr", p, ctr);
        chk_word("left", 0, expq.size());
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h1C58E52B));
        cs = 3'($urandom);
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        m.wt(3);
        ctl({4'hB, cs, 1'b0}, 1'b0);
        m.stop;
        for (int k = 0; k < 8; k++) begin
            ctl({4'hA, k[2:0], 1'b0}, k == cs);
            m.stop;
        end
        ctl({4'hA, cs, 1'b1}, 1'b1);
        chk_bit("rd", 1'b1, rd_sel);
        m.stop;
        // two straps left open read low; the master sends their bits as 0
        cs[1:0] = 2'b00;
        ctl({4'hA, cs[2], 2'b00, 1'b0}, 1'b1);
        m.stop;
        wr(1, 1'b0);
        wr(PS + 3, 1'b0);
        wr(3, 1'b0);
        wr(2, 1'b1);
        wr(1 + $urandom % PS, 1'b0);
        stop_test;
    end
    // watchdog, well past the expected run
    initial begin
        #3000000;
        err_total++;
        stop_test;
    end
endmodule // seew_slave_tb

/* File: seew_sync.v */
`timescale 1ns/1ps

// ********************************************
// two flop synchroniser for one pin
// ********************************************
module seew_sync (
    // clock and reset
    input wire clk,
    input wire rst,
    // pin and its synchronised level
    input wire pin_in,
    output reg pin_sync_ff
);

reg pin_meta_ff;

// reset high: an idle bus line rests high
always @(posedge clk or posedge rst) begin
    if (rst) begin
        pin_meta_ff <= 1'b1;
        pin_sync_ff <= 1'b1;
    end else begin
        pin_meta_ff <= pin_in;
        pin_sync_ff <= pin_meta_ff;
    end
end

endmodule // seew_sync

/* File: seew_timer.v */
`timescale 1ns/1ps

// ********************************************
// self-timed write cycle counter
// ********************************************
module seew_timer #(
    parameter CYCLES = 125000
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // start pulse and busy level
    input wire start,
    output reg busy_ff
);

reg [31:0] count_ff;

// count down from start; busy until the count expires
always @(posedge clk or posedge rst) begin
    if (rst) begin
        count_ff <= 32'h00000000;
        busy_ff <= 1'b0;
    end else if (start) begin
        count_ff <= CYCLES[31:0];
        busy_ff <= 1'b1;
    end else if (count_ff > 32'h00000001) begin
        count_ff <= count_ff - 32'h00000001;
    end else begin
        count_ff <= 32'h00000000;
        busy_ff <= 1'b0;
    end
end

endmodule // seew_timer
